/* File: cra_pkg.sv */
`default_nettype none
package cra_pkg;
	// ==========================================
	// Address map, 11-bit byte-wide registers
	localparam int ADDR_W = 11;
	localparam logic [10:0] ADDR_TOP = 11'h6FF;
	localparam logic [10:0] A_BANK = 11'h000;
	localparam logic [10:0] A_PFC1 = 11'h00E;
	localparam logic [10:0] A_P0SS = 11'h012;
	localparam logic [10:0] A_STAT_LO = 11'h040;
	localparam logic [10:0] A_STAT_HI = 11'h05F;
	localparam logic [10:0] A_LTST = 11'h05D;
	localparam logic [10:0] A_IEN = 11'h05E;
	localparam logic [10:0] A_EDGE = 11'h05F;
	localparam logic [10:0] A_FOFS = 11'h100;
	localparam logic [10:0] A_POFS = 11'h105;
	localparam logic [10:0] A_FRBK = 11'h110;
	localparam logic [10:0] A_PRBK = 11'h114;
	// Status byte index (address minus A_STAT_LO)
	localparam logic [4:0] SI_GLOB = 5'h03;
	localparam logic [4:0] SI_RTST = 5'h1C;
	localparam logic [4:0] SI_LTST = 5'h1D;
	// ==========================================
	// Reset values and codes
	localparam logic [7:0] RST_BANK = 8'h00;
	localparam logic [7:0] RST_PFC = 8'h00;
	localparam logic [7:0] RST_PSS = 8'h00;
	localparam logic [7:0] RST_IEN = 8'h00;
	localparam logic [7:0] RST_EDGE = 8'h55;
	localparam logic [3:0] FN_FOLLOW = 4'h4;
	localparam logic [3:0] FN_WIREOR = 4'h6;
	localparam logic [1:0] CS_DIRECT = 2'h0;
	localparam int NVM_DEPTH = 1792;
	localparam int N_STAT = 4;
	// ==========================================
	// Multi-byte field decode
	localparam logic [1:0] F_FOFS = 2'h0;
	localparam logic [1:0] F_POFS = 2'h1;
	localparam logic [1:0] F_FRBK = 2'h2;
	localparam logic [1:0] F_PRBK = 2'h3;
	localparam logic [2:0] LAST_FOFS = 3'h4;
	localparam logic [2:0] LAST_W4 = 3'h3;
	typedef struct packed {
		logic hit;
		logic ro;
		logic last;
		logic [1:0] fid;
		logic [2:0] idx;
	} cra_mb_s;
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_DO = 1'b1
	} cra_st_e;
	// Which multi-byte field and byte an address hits
	function automatic cra_mb_s cra_mb_dec(input logic [10:0] a);
		cra_mb_s m;
		logic [10:0] d;
		m = '0;
		d = '0;
		if (a >= A_FOFS && a <= A_FOFS + 11'h004) begin
			d = a - A_FOFS;
			m.fid = F_FOFS;
			m.last = (d[2:0] == LAST_FOFS);
			m.hit = 1'b1;
		end else if (a >= A_POFS && a <= A_POFS + 11'h003) begin
			d = a - A_POFS;
			m.fid = F_POFS;
			m.last = (d[2:0] == LAST_W4);
			m.hit = 1'b1;
		end else if (a >= A_FRBK && a <= A_PRBK + 11'h003) begin
			d = (a >= A_PRBK) ? a - A_PRBK : a - A_FRBK;
			m.fid = (a >= A_PRBK) ? F_PRBK : F_FRBK;
			m.ro = 1'b1;
			m.hit = 1'b1;
		end
		m.idx = d[2:0];
		return m;
	endfunction
endpackage
`default_nettype wire

/* File: cra_xfer_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Link-to-core handshake, toggle based
interface cra_xfer_if;
	logic req_tog;
	logic wr;
	logic [10:0] addr;
	logic [7:0] wdata;
	logic ack_tog;
	logic [7:0] rdata;
	modport link (output req_tog, output wr, output addr, output wdata, input ack_tog, input rdata);
	modport core (input req_tog, input wr, input addr, input wdata, output ack_tog, output rdata);
endinterface
`default_nettype wire

/* File: cra_link_port.sv */
`timescale 1ns/1ps
`default_nettype none
module cra_link_port
	import cra_pkg::*;
(
	input wire logic link_clk_in,
	input wire logic link_rst_b_in,
	input wire logic link_req_in,
	input wire logic link_wr_in,
	input wire logic [10:0] link_addr_in,
	input wire logic [7:0] link_wdata_in,
	output logic link_ack_out,
	output logic [7:0] link_rdata_out,
	output logic link_busy_out,
	cra_xfer_if.link xf
);
	logic req_tog_ff;
	logic wr_ff;
	logic [10:0] addr_ff;
	logic [7:0] wdata_ff;
	logic ack_s1_ff, ack_s2_ff, ack_s3_ff;
	logic busy;

	assign busy = req_tog_ff ^ ack_s2_ff;
	assign xf.req_tog = req_tog_ff;
	assign xf.wr = wr_ff;
	assign xf.addr = addr_ff;
	assign xf.wdata = wdata_ff;

	// ==========================================
	// Request capture; held stable until the core answers
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_b_in) begin
			req_tog_ff <= 1'b0;
			wr_ff <= 1'b0;
			addr_ff <= '0;
			wdata_ff <= '0;
		end else if (link_req_in && !busy) begin
			req_tog_ff <= ~req_tog_ff;
			wr_ff <= link_wr_in;
			addr_ff <= link_addr_in;
			wdata_ff <= link_wdata_in;
		end
	end

	// Answer toggle synchroniser and pulse
	always_ff @(posedge link_clk_in) begin
		if (!link_rst_b_in) begin
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
			ack_s3_ff <= 1'b0;
			link_ack_out <= 1'b0;
			link_rdata_out <= '0;
			link_busy_out <= 1'b0;
		end else begin
			ack_s1_ff <= xf.ack_tog;
			ack_s2_ff <= ack_s1_ff;
			ack_s3_ff <= ack_s2_ff;
			link_ack_out <= ack_s2_ff ^ ack_s3_ff;
			link_busy_out <= busy || (link_req_in && !busy);
			if (ack_s2_ff ^ ack_s3_ff) begin
				link_rdata_out <= xf.rdata; // Stable: core holds it until next request
			end
		end
	end
endmodule // cra_link_port
`default_nettype wire

/* File: cra_core.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] Test strap 1 and select pins 00 at reset-pin rise enter direct write mode.
// [RULE2] Direct mode maps nonvolatile memory over the whole map; registers unreachable.
// [RULE3] Test strap 0 at reset-pin rise leaves direct write mode.
// [RULE4] Serial data output enable held on throughout direct write mode.
// [RULE5] Source 0x1F plus function 0x04 drives pin 0 from config-done, low means reset.
// [RULE6] Function 0x06 drives pin low only, for wire-OR with external pullup.
// [RULE7] Scripts reach the second channel by adding 0x4000 to addresses.
// [RULE8] Byte registers decoded 000h to 6FFh, bit 7 most significant.
// [RULE9] Software writes zero to unlisted addresses and reserved bits.
// [RULE10] Software writes fixed-0 and fixed-1 bits with their fixed values.
// [RULE11] Writes to read-only fields are dropped; other fields read and write.
// [RULE12] Real-time status reads return the live signal level.
// [RULE13] Latched bits set on chosen edge, clear on write-one, hold on write-zero.
// [RULE14] Latched bit with its enable set raises the interrupt request.
// [RULE15] Reset returns every configuration field to its default.
// [RULE16] Multi-byte writes collect in holding; last byte commits whole field.
// [RULE17] Reads during a pending multi-byte write see the current field.
// [RULE18] Reading the lowest byte snapshots the field; higher bytes read snapshot.
// [RULE19] Writes during a multi-byte read overwrite the read snapshot bytes.
// [RULE20] One shared write holding and one shared read holding register.
// [RULE21] Fields: 40-bit and 32-bit offsets writable, two 32-bit readbacks read-only.
// [RULE22] Bank select at 0x0; 0 shows registers, 1 shows nonvolatile memory above.
module cra_core
	import cra_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic link_clk_in,
	input wire logic link_rst_b_in,
	input wire logic link_req_in,
	input wire logic link_wr_in,
	input wire logic [10:0] link_addr_in,
	input wire logic [7:0] link_wdata_in,
	output logic link_ack_out,
	output logic [7:0] link_rdata_out,
	output logic link_busy_out,
	input wire logic reset_n_pin_in,
	input wire logic test_strap_in,
	input wire logic [1:0] config_select_pins_in,
	input wire logic config_done_flag_in,
	input wire logic [3:0] status_in,
	input wire logic [31:0] freq_meas_in,
	input wire logic [31:0] phase_meas_in,
	output logic [39:0] freq_offset_word_out,
	output logic [31:0] phase_offset_word_out,
	output logic gpio0_out,
	output logic gpio0_oe_out,
	output logic sdo_oe_out,
	output logic int_req_out,
	output logic direct_mode_out
);
	// ==========================================
	// Link crossing
	cra_xfer_if xf ();
	logic [7:0] rdata_ff;
	logic ack_tog_ff;
	logic req_s1_ff, req_s2_ff, req_s3_ff;

	assign xf.ack_tog = ack_tog_ff;
	assign xf.rdata = rdata_ff;

	cra_link_port u_link (
		.link_clk_in(link_clk_in),
		.link_rst_b_in(link_rst_b_in),
		.link_req_in(link_req_in),
		.link_wr_in(link_wr_in),
		.link_addr_in(link_addr_in),
		.link_wdata_in(link_wdata_in),
		.link_ack_out(link_ack_out),
		.link_rdata_out(link_rdata_out),
		.link_busy_out(link_busy_out),
		.xf(xf.link)
	);

	// Request toggle synchroniser
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			req_s1_ff <= 1'b0;
			req_s2_ff <= 1'b0;
			req_s3_ff <= 1'b0;
		end else begin
			req_s1_ff <= xf.req_tog;
			req_s2_ff <= req_s1_ff;
			req_s3_ff <= req_s2_ff;
		end
	end

	// ==========================================
	// Pin synchronisers and strap capture
	logic [3:0] pin_s1_ff, pin_s2_ff;
	logic rst_pin_d_ff;
	logic direct_ff;
	logic cfg_rst;

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			rst_pin_d_ff <= 1'b0;
		end else begin
			pin_s1_ff <= {reset_n_pin_in, test_strap_in, config_select_pins_in};
			pin_s2_ff <= pin_s1_ff;
			rst_pin_d_ff <= pin_s2_ff[3];
		end
	end

	// Reset pin low also clears configuration
	assign cfg_rst = !rst_b_in || !pin_s2_ff[3];

	// Straps caught after release, never under reset itself
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			direct_ff <= 1'b0;
		end else if (pin_s2_ff[3] && !rst_pin_d_ff) begin
			if (!pin_s2_ff[2]) begin
				direct_ff <= 1'b0; // [RULE3]
			end else if (pin_s2_ff[1:0] == CS_DIRECT) begin
				direct_ff <= 1'b1; // [RULE1]
			end
		end
	end

	// ==========================================
	// Access sequencer
	cra_st_e st_ff;
	logic [10:0] acc_addr_ff;
	logic [7:0] acc_wdata_ff;
	logic acc_wr_ff;
	logic [7:0] bank_ff;
	logic wr_go, rd_go, in_nvm, in_map;
	cra_mb_s mb;

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			st_ff <= ST_IDLE;
			acc_addr_ff <= '0;
			acc_wdata_ff <= '0;
			acc_wr_ff <= 1'b0;
		end else begin
			case (st_ff)
				ST_IDLE: begin
					if (req_s2_ff ^ req_s3_ff) begin
						st_ff <= ST_DO;
						acc_addr_ff <= xf.addr;
						acc_wdata_ff <= xf.wdata;
						acc_wr_ff <= xf.wr;
					end
				end
				ST_DO: st_ff <= ST_IDLE;
				default: st_ff <= ST_IDLE;
			endcase
		end
	end

	assign in_map = (acc_addr_ff <= ADDR_TOP); // [RULE8]
	assign in_nvm = direct_ff || (bank_ff[0] && acc_addr_ff != A_BANK); // [RULE2] [RULE22]
	assign wr_go = (st_ff == ST_DO) && acc_wr_ff && in_map;
	assign rd_go = (st_ff == ST_DO) && !acc_wr_ff && in_map;
	assign mb = cra_mb_dec(acc_addr_ff);

	// ==========================================
	// Configuration registers
	logic [7:0] pfc_ff, pss_ff, ien_ff, edge_ff;
	logic reg_wr;

	// Register writes only when the register bank is mapped
	assign reg_wr = wr_go && !in_nvm;

	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			bank_ff <= RST_BANK; // [RULE15]
			pfc_ff <= RST_PFC;
			pss_ff <= RST_PSS;
			ien_ff <= RST_IEN;
			edge_ff <= RST_EDGE;
		end else if (reg_wr) begin
			case (acc_addr_ff)
				A_BANK: bank_ff <= {7'h00, acc_wdata_ff[0]}; // [RULE22]
				A_PFC1: pfc_ff <= acc_wdata_ff;
				A_P0SS: pss_ff <= acc_wdata_ff;
				A_IEN: ien_ff <= {4'h0, acc_wdata_ff[3:0]};
				A_EDGE: edge_ff <= acc_wdata_ff;
				default: ; // Read-only or unlisted: dropped [RULE11]
			endcase
		end
	end

	// ==========================================
	// Nonvolatile memory image
	logic [7:0] nvm_mem [NVM_DEPTH];

	// No reset: models stored contents, not control state
	always_ff @(posedge clk_in) begin
		if (wr_go && in_nvm) begin
			nvm_mem[acc_addr_ff] <= acc_wdata_ff; // [RULE2]
		end
	end

	// ==========================================
	// Status bits
	logic [N_STAT-1:0] prev_ff, lt_ff;

	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= status_in;
		end
	end

	generate
		for (genvar i = 0; i < N_STAT; i++) begin : g_lat
			logic ev, clr;
			assign ev = (edge_ff[2*i] && status_in[i] && !prev_ff[i]) ||
				(edge_ff[2*i+1] && !status_in[i] && prev_ff[i]);
			assign clr = reg_wr && acc_addr_ff == A_LTST && acc_wdata_ff[i];
			// Set beats a clear landing in the same cycle
			always_ff @(posedge clk_in) begin
				if (cfg_rst) begin
					lt_ff[i] <= 1'b0;
				end else if (ev) begin
					lt_ff[i] <= 1'b1; // [RULE13]
				end else if (clr) begin
					lt_ff[i] <= 1'b0; // [RULE13]
				end
			end
		end
	endgenerate

	// Interrupt request from enabled latched bits
	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			int_req_out <= 1'b0;
		end else begin
			int_req_out <= |(lt_ff & ien_ff[N_STAT-1:0]); // [RULE14]
		end
	end

	// Status byte by index above the status base
	function automatic logic [7:0] stat_byte(input logic [4:0] si, input logic done,
		input logic [3:0] rt, input logic [3:0] lt);
		case (si)
			SI_GLOB: stat_byte = {done, 7'h00};
			SI_RTST: stat_byte = {4'h0, rt}; // [RULE12]
			SI_LTST: stat_byte = {4'h0, lt};
			default: stat_byte = 8'h00;
		endcase
	endfunction

	// ==========================================
	// Multi-byte fields and holding registers
	logic [31:0] wr_hold_ff, rd_hold_ff;
	logic [39:0] fvec;
	logic [2:0] idx_m1;

	assign idx_m1 = mb.idx - 3'h1;

	always_comb begin
		case (mb.fid)
			F_FOFS: fvec = freq_offset_word_out;
			F_POFS: fvec = {8'h00, phase_offset_word_out};
			F_FRBK: fvec = {8'h00, freq_meas_in};
			default: fvec = {8'h00, phase_meas_in};
		endcase
	end

	// Shared write holding and committed fields
	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			wr_hold_ff <= '0;
			freq_offset_word_out <= '0;
			phase_offset_word_out <= '0;
		end else if (reg_wr && mb.hit && !mb.ro) begin // [RULE11] [RULE21]
			if (!mb.last) begin
				wr_hold_ff[{mb.idx[1:0], 3'h0} +: 8] <= acc_wdata_ff; // [RULE16] [RULE20]
			end else if (mb.fid == F_FOFS) begin
				freq_offset_word_out <= {acc_wdata_ff, wr_hold_ff}; // [RULE16]
			end else begin
				phase_offset_word_out <= {acc_wdata_ff, wr_hold_ff[23:0]}; // [RULE16]
			end
		end
	end

	// Shared read snapshot
	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			rd_hold_ff <= '0;
		end else if (rd_go && !in_nvm && mb.hit && mb.idx == 3'h0) begin
			rd_hold_ff <= fvec[39:8]; // [RULE18] [RULE20]
		end else if (reg_wr && mb.hit && !mb.ro && mb.idx != 3'h0) begin
			rd_hold_ff[{idx_m1[1:0], 3'h0} +: 8] <= acc_wdata_ff; // [RULE19]
		end
	end

	// ==========================================
	// Read data and answer
	logic [7:0] rd_val;
	logic [10:0] soff;

	assign soff = acc_addr_ff - A_STAT_LO;

	always_comb begin
		rd_val = 8'h00;
		if (!in_map) begin
			rd_val = 8'h00;
		end else if (in_nvm) begin
			rd_val = nvm_mem[acc_addr_ff];
		end else if (mb.hit) begin
			if (mb.idx == 3'h0) begin
				rd_val = fvec[7:0]; // [RULE17]
			end else begin
				rd_val = rd_hold_ff[{idx_m1[1:0], 3'h0} +: 8]; // [RULE18]
			end
		end else if (acc_addr_ff >= A_STAT_LO && acc_addr_ff <= A_STAT_HI && acc_addr_ff != A_IEN &&
			acc_addr_ff != A_EDGE) begin
			rd_val = stat_byte(soff[4:0], config_done_flag_in, status_in, lt_ff);
		end else begin
			case (acc_addr_ff)
				A_BANK: rd_val = bank_ff;
				A_PFC1: rd_val = pfc_ff;
				A_P0SS: rd_val = pss_ff;
				A_IEN: rd_val = ien_ff;
				A_EDGE: rd_val = edge_ff;
				default: rd_val = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			rdata_ff <= '0;
			ack_tog_ff <= 1'b0;
		end else if (st_ff == ST_DO) begin
			rdata_ff <= acc_wr_ff ? 8'h00 : rd_val;
			ack_tog_ff <= ~ack_tog_ff;
		end
	end

	// ==========================================
	// Pin 0 routing and data output enable
	logic [7:0] src_byte;
	logic src_bit;

	assign src_byte = stat_byte(pss_ff[7:3], config_done_flag_in, status_in, lt_ff);
	assign src_bit = src_byte[pss_ff[2:0]];

	always_ff @(posedge clk_in) begin
		if (cfg_rst) begin
			gpio0_out <= 1'b0;
			gpio0_oe_out <= 1'b0;
		end else begin
			case (pfc_ff[3:0])
				FN_FOLLOW: begin
					gpio0_out <= src_bit; // [RULE5]
					gpio0_oe_out <= 1'b1;
				end
				FN_WIREOR: begin
					gpio0_out <= 1'b0; // Pull low only; pullup makes the high [RULE6]
					gpio0_oe_out <= !src_bit;
				end
				default: begin
					gpio0_out <= 1'b0;
					gpio0_oe_out <= 1'b0;
				end
			endcase
		end
	end

	// Outside direct mode the line is driven only while a transfer is open
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sdo_oe_out <= 1'b0;
			direct_mode_out <= 1'b0;
		end else begin
			sdo_oe_out <= direct_ff || (req_s2_ff ^ ack_tog_ff); // [RULE4]
			direct_mode_out <= direct_ff;
		end
	end
endmodule // cra_core
`default_nettype wire

/* File: cra_core_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checks of the channel register core
module cra_core_props
	import cra_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic link_clk_in,
	input wire logic link_rst_b_in,
	input wire logic link_req_in,
	input wire logic link_ack_out,
	input wire logic [7:0] link_rdata_out,
	input wire logic link_busy_out,
	input wire logic reset_n_pin_in,
	input wire logic test_strap_in,
	input wire logic [1:0] config_select_pins_in,
	input wire logic gpio0_oe_out,
	input wire logic sdo_oe_out,
	input wire logic int_req_out,
	input wire logic direct_mode_out
);
	logic [3:0] pin_hi_ff;
	// Age of the reset pin release; a mode change far from it is a stray capture
	always_ff @(posedge clk_in) begin
		if (!reset_n_pin_in) begin
			pin_hi_ff <= 4'h0;
		end else if (pin_hi_ff != 4'hF) begin
			pin_hi_ff <= pin_hi_ff + 4'h1;
		end
	end
	// ==========================================
	// Link handshake
	ack_pulse_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_b_in)
		link_ack_out |=> !link_ack_out) else $error("answer pulse too long");
	take_busy_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_b_in)
		link_req_in && !link_busy_out |-> ##[1:2] link_busy_out) else $error("busy not raised");
	ack_bound_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_b_in)
		link_req_in && !link_busy_out |-> ##[2:8] link_ack_out) else $error("no answer in time");
	busy_clear_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_b_in)
		link_ack_out |=> !link_busy_out) else $error("busy held after answer");
	rdata_hold_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_b_in)
		$changed(link_rdata_out) |-> link_ack_out) else $error("read data moved without answer");
	// ==========================================
	// Pins and modes
	mode_enter_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$rose(direct_mode_out) |-> test_strap_in && config_select_pins_in == CS_DIRECT
		&& pin_hi_ff != 4'h0 && pin_hi_ff < 4'h9) else $error("direct mode entered wrongly");
	mode_leave_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$fell(direct_mode_out) |-> !test_strap_in && pin_hi_ff != 4'h0 && pin_hi_ff < 4'h9)
		else $error("direct mode left wrongly");
	sdo_direct_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		direct_mode_out && $past(direct_mode_out) |-> sdo_oe_out) else $error("data out released");
	pin_reset_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!reset_n_pin_in [*6] |-> !int_req_out && !gpio0_oe_out) else $error("pin reset ignored");
endmodule // cra_core_props
bind cra_core cra_core_props u_props (.clk_in, .rst_b_in, .link_clk_in, .link_rst_b_in, .link_req_in,
	.link_ack_out, .link_rdata_out, .link_busy_out, .reset_n_pin_in, .test_strap_in,
	.config_select_pins_in, .gpio0_oe_out, .sdo_oe_out, .int_req_out, .direct_mode_out);
`default_nettype wire

/* File: cra_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host processor on the link side
module cra_host_model (
	input wire logic link_clk_in,
	input wire logic link_ack_in,
	input wire logic [7:0] link_rdata_in,
	output logic link_req_out,
	output logic link_wr_out,
	output logic [10:0] link_addr_out,
	output logic [7:0] link_wdata_out
);
	initial begin
		link_req_out = 1'b0;
		link_wr_out = 1'b0;
		link_addr_out = 11'h000;
		link_wdata_out = 8'h00;
	end
	// One access; ok stays low when no answer comes
	task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		ok = 1'b0;
		q = 8'h00;
		if (a[14]) return; // Second channel sits 0x4000 higher, not on this port
		@(posedge link_clk_in);
		link_req_out <= 1'b1;
		link_wr_out <= wr;
		link_addr_out <= a[10:0];
		link_wdata_out <= d;
		@(posedge link_clk_in);
		// Released lines show junk so stale values cannot pass
		link_req_out <= 1'b0;
		link_wr_out <= ~wr;
		link_addr_out <= ~a[10:0];
		link_wdata_out <= ~d;
		for (int n = 0; n < 12 && !ok; n++) begin
			@(posedge link_clk_in);
			if (link_ack_in === 1'b1) begin
				ok = 1'b1;
				q = link_rdata_in;
			end
		end
	endtask
endmodule // cra_host_model
`default_nettype wire

/* File: cra_core_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cra_core_test;
	import cra_pkg::*;
	logic clk_in, rst_b_in, link_clk_in, link_rst_b_in, req, wr_l, ack, busy, pin, strap, done;
	logic gpio, gpio_oe, sdo_oe, int_req, dmode, ok;
	logic [10:0] addr;
	logic [7:0] wd, rdat, rd;
	logic [1:0] csel;
	logic [3:0] stat;
	logic [31:0] fmeas, pmeas, pofs;
	logic [39:0] fofs;
	int miscompares, cmp_count;
	cra_core DUT (.clk_in, .rst_b_in, .link_clk_in, .link_rst_b_in, .link_req_in(req), .link_wr_in(wr_l),
		.link_addr_in(addr), .link_wdata_in(wd), .link_ack_out(ack), .link_rdata_out(rdat),
		.link_busy_out(busy), .reset_n_pin_in(pin), .test_strap_in(strap), .config_select_pins_in(csel),
		.config_done_flag_in(done), .status_in(stat), .freq_meas_in(fmeas), .phase_meas_in(pmeas),
		.freq_offset_word_out(fofs), .phase_offset_word_out(pofs), .gpio0_out(gpio), .gpio0_oe_out(gpio_oe),
		.sdo_oe_out(sdo_oe), .int_req_out(int_req), .direct_mode_out(dmode));
	cra_host_model host (.link_clk_in, .link_ack_in(ack), .link_rdata_in(rdat), .link_req_out(req),
		.link_wr_out(wr_l), .link_addr_out(addr), .link_wdata_out(wd));
	// ==========================================
	// Clocks; link phase offset on purpose
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	initial begin
		link_clk_in = 1'b0;
		#17;
		forever #62.5 link_clk_in = ~link_clk_in;
	end
	// ==========================================
	// Shared helpers
	task check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task results;
		$display("Compares %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task acc(input logic w, input logic [10:0] a, input logic [7:0] d);
		host.xfer(w, {5'h00, a}, d, rd, ok);
		if (!ok) begin
			miscompares++;
			results();
		end
	endtask
	task wr(input logic [10:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask
	task rdchk(input logic [10:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		check(rd, e);
	endtask
	task clk_set(input logic [3:0] s, input logic dn);
		@(posedge clk_in);
		stat <= s;
		done <= dn;
		repeat (6) @(posedge clk_in);
	endtask
	// Reset pin pulse with straps held steady around the rise
	task pin_pulse(input logic ts, input logic [1:0] cs);
		@(posedge clk_in);
		strap <= ts;
		csel <= cs;
		repeat (3) @(posedge clk_in);
		pin <= 1'b0;
		repeat (8) @(posedge clk_in);
		pin <= 1'b1;
		repeat (12) @(posedge clk_in);
	endtask
	// ==========================================
	// Scenarios
	task t_defaults;
		rdchk(A_BANK, RST_BANK);
		rdchk(A_PFC1, RST_PFC);
		rdchk(A_P0SS, RST_PSS);
		rdchk(A_IEN, RST_IEN);
		rdchk(A_EDGE, RST_EDGE);
		wr(11'h7FF, 8'h00);
		rdchk(11'h700, 8'h00);
		$display("t_defaults done");
	endtask
	task t_status;
		clk_set(4'hA, 1'b0);
		rdchk(11'h05C, 8'h0A);
		wr(11'h05C, 8'h05);
		clk_set(4'h5, 1'b0);
		rdchk(11'h05C, 8'h05);
		wr(A_LTST, 8'h0F);
		rdchk(A_LTST, 8'h00);
		wr(A_IEN, 8'h01);
		clk_set(4'h4, 1'b0);
		rdchk(A_LTST, 8'h00);
		check(int_req, 1'b0);
		wr(A_EDGE, 8'h56); // Signal 0 now on its falling edge only
		clk_set(4'h5, 1'b0);
		rdchk(A_LTST, 8'h00);
		clk_set(4'h4, 1'b0);
		rdchk(A_LTST, 8'h01);
		check(int_req, 1'b1);
		wr(A_LTST, 8'h00); // Reserved bits always sent as zero
		rdchk(A_LTST, 8'h01);
		wr(A_LTST, 8'h01);
		rdchk(A_LTST, 8'h00);
		check(int_req, 1'b0);
		wr(A_EDGE, 8'h57); // Signal 0 on either edge
		clk_set(4'h5, 1'b0);
		rdchk(A_LTST, 8'h01);
		wr(A_LTST, 8'h01);
		clk_set(4'h4, 1'b0);
		rdchk(A_LTST, 8'h01);
		wr(A_LTST, 8'h01);
		rdchk(A_LTST, 8'h00);
		$display("t_status done");
	endtask
	task t_multi;
		for (int i = 0; i < 5; i++) wr(A_FOFS + 11'(i), 8'(i + 1));
		check(fofs, 40'h0504030201);
		for (int i = 0; i < 4; i++) wr(A_FOFS + 11'(i), 8'hAA);
		check(fofs, 40'h0504030201);
		rdchk(A_FOFS, 8'h01);
		wr(A_FOFS + 11'h004, 8'hEE);
		check(fofs, 40'hEEAAAAAAAA);
		for (int i = 0; i < 4; i++) wr(A_POFS + 11'(i), 8'h11 * 8'(i + 1));
		check(pofs, 32'h44332211);
		rdchk(A_POFS, 8'h11);
		wr(A_POFS + 11'h001, 8'h5A); // Lands in both holding registers
		rdchk(A_POFS + 11'h001, 8'h5A);
		rdchk(A_POFS + 11'h002, 8'h33);
		check(pofs, 32'h44332211);
		rdchk(A_FRBK, 8'hEF);
		wr(A_FRBK + 11'h001, 8'h00); // Read-only readback byte: must not touch the snapshot
		@(posedge clk_in);
		fmeas <= 32'h00000000;
		repeat (6) @(posedge clk_in);
		rdchk(A_FRBK + 11'h001, 8'hCD);
		rdchk(A_PRBK, 8'h67);
		rdchk(A_FRBK + 11'h002, 8'h23);
		$display("t_multi done");
	endtask
	task t_bank;
		wr(A_BANK, 8'h01);
		rdchk(A_BANK, 8'h01);
		wr(A_PFC1, 8'h5A);
		rdchk(A_PFC1, 8'h5A);
		wr(A_BANK, 8'h00);
		rdchk(A_PFC1, RST_PFC);
		$display("t_bank done");
	endtask
	task t_gpio;
		wr(A_P0SS, 8'h1F);
		wr(A_PFC1, 8'h04);
		check({gpio_oe, gpio}, 2'b10);
		clk_set(4'h4, 1'b1);
		check({gpio_oe, gpio}, 2'b11);
		rdchk(A_STAT_LO + 11'h003, 8'h80);
		wr(A_PFC1, 8'h06);
		check(gpio_oe, 1'b0);
		clk_set(4'h4, 1'b0);
		check({gpio_oe, gpio}, 2'b10);
		$display("t_gpio done");
	endtask
	task t_direct;
		pin_pulse(1'b1, 2'h0);
		check({dmode, sdo_oe}, 2'b11);
		wr(A_BANK, 8'h33);
		rdchk(A_BANK, 8'h33);
		check(sdo_oe, 1'b1);
		pin_pulse(1'b1, 2'h1);
		check(dmode, 1'b1);
		pin_pulse(1'b0, 2'h0);
		check(dmode, 1'b0);
		check(fofs, 40'h0000000000);
		rdchk(A_IEN, RST_IEN);
		rdchk(A_EDGE, RST_EDGE);
		$display("t_direct done");
	endtask
	// ==========================================
	// Main sequence
	initial begin
		miscompares = 0;
		cmp_count = 0;
		rst_b_in = 1'b0;
		link_rst_b_in = 1'b0;
		pin = 1'b0;
		strap = 1'b0;
		csel = 2'h1;
		done = 1'b0;
		stat = 4'h0;
		fmeas = 32'h89ABCDEF;
		pmeas = 32'h01234567;
		repeat (2) @(posedge link_clk_in);
		link_rst_b_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		rst_b_in <= 1'b1;
		pin <= 1'b1;
		repeat (10) @(posedge clk_in);
		t_defaults();
		t_status();
		t_multi();
		t_bank();
		t_gpio();
		t_direct();
		results();
	end
endmodule // cra_core_test
`default_nettype wire
